//--- hdl/lcs_sequencer.sv
// Lubrication cycle sequencer with APB configuration registers
`timescale 1ns/1ps
// Function
// - Cycle mode ends lube on sensor or run timer; pulse mode times both phases by pulses.
// - Monitoring: timer or pressure in cycle mode; none or pressure in pulse.
// - Standby ends by timer, first of timer/count, count, or count with alarm.
// - Raise timeout alarm when a cycle misses its completion time, except under timer monitoring.
// - Timer monitoring runs the pump for run duration per cycle.
// - A lubrication phase holds the configured number of cycles.
// - Idle for the inter-cycle gap between cycles of one phase.
// - Power-on enters standby, lubrication or the saved phase.
// - Initial cycles are added to the first lubrication phase.
// - Standard style drops the relay on alarm; coded style pulses it.
// - Halt policy chooses which alarms stop lubrication.
// - Keep pumping for the hold time after the pressure switch closes.
// - Suspend input stops operation when suspend is enabled.
// - Pulse mode alarms when no pulse arrives within watchdog time.
// - Cycle mode standby pulse count; zero means timer only.
// - Pulse mode standby length is the standby pulse count.
// - Standby pulse count is scaled by 1, 10 or 100.
// - Pulse mode lube cycle length is the run pulse count.
// - Factory restore returns every setting to its default.
// - Coded alarm bursts of 500 ms, 500 ms apart, with 2000 ms gap after each group of bursts.
module lcs_sequencer #(
   parameter int TICK_CYC = lcs_pkg::TICK_CYC
) (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic pressure_sw_in,
   input wire logic pulse_in,
   input wire logic low_level_in,
   input wire logic suspend_in,
   input wire logic resume_lube_in,
   output logic pump_on_out,
   output logic alarm_relay_out
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] sby;
      logic [31:0] times;
      logic [31:0] counts;
      logic [31:0] pulses;
      logic [31:0] wdog;
      logic ack;
      logic err;
      logic [31:0] rdata;
      logic [22:0] pre;
      lcs_pkg::lcs_phase_e ph;
      logic [1:0] boot;
      logic first;
      logic [21:0] tm;
      logic [22:0] pcnt;
      logic [8:0] cyc;
      logic [8:0] target;
      logic ps_seen;
      logic [11:0] ht;
      logic [10:0] wd;
      logic [3:0] alm;
      lcs_pkg::lcs_relay_e ry;
      logic [4:0] rcnt;
      logic [3:0] rn;
      logic relay;
      logic pump;
   } lcs_state_s;
   lcs_state_s st;
   lcs_state_s n;

   logic ps_lvl, pulse_rise, low_lvl, susp_lvl, resume_lvl;
   logic mode_pulse, mon_ps, susp_act, halt, stall, tick, tout_on;
   logic done, sby_end, cnt_ok, tim_ok, wr, set_wdog;
   logic [1:0] src;
   logic [21:0] lim_sby, lim_tout, lim_run, lim_gap;
   logic [11:0] lim_hold;
   logic [10:0] lim_wd;
   logic [22:0] sby_eff, scale;
   logic [3:0] code;
   logic [3:0] set_alm;
   logic [31:0] rd;
   logic hit;

   lcs_sync_edge u_ps (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .async_in(pressure_sw_in), .level_out(ps_lvl), .rise_out());
   lcs_sync_edge u_pulse (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .async_in(pulse_in), .level_out(), .rise_out(pulse_rise));
   lcs_sync_edge u_low (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .async_in(low_level_in), .level_out(low_lvl), .rise_out());
   lcs_sync_edge u_susp (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .async_in(suspend_in), .level_out(susp_lvl), .rise_out());
   lcs_sync_edge u_res (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .async_in(resume_lube_in), .level_out(resume_lvl), .rise_out());

   always_comb begin
      mode_pulse = st.ctrl[lcs_pkg::B_MODE];
      mon_ps = st.ctrl[lcs_pkg::B_MON];
      src = st.ctrl[lcs_pkg::B_SRC +: 2];
      tick = (st.pre == 23'(TICK_CYC - 1));
      lim_sby = 22'(st.sby[18:0]) * 22'(lcs_pkg::TICKS_PER_S);
      lim_tout = 22'(st.times[lcs_pkg::F_TOUT +: 8]) *
         22'(lcs_pkg::TICKS_PER_S);
      lim_run = 22'(st.times[lcs_pkg::F_RUN +: 8]) *
         22'(lcs_pkg::TICKS_PER_S);
      lim_gap = 22'(st.times[lcs_pkg::F_GAP +: 8]) *
         22'(lcs_pkg::TICKS_PER_S);
      lim_hold = 12'(st.times[lcs_pkg::F_PSH +: 8]) *
         12'(lcs_pkg::TICKS_PER_S);
      lim_wd = st.wdog[10:0];
      case (st.ctrl[lcs_pkg::B_SCALE +: 2])
         lcs_pkg::SCALE_10: scale = 23'd10;
         lcs_pkg::SCALE_100: scale = 23'd100;
         default: scale = 23'd1;
      endcase
      sby_eff = 23'(st.pulses[lcs_pkg::F_SBP +: 16]) * scale;
      susp_act = st.ctrl[lcs_pkg::B_HOLD] & susp_lvl;
      case (st.ctrl[lcs_pkg::B_HALT +: 2])
         lcs_pkg::HALT_NONE: halt = 1'b0;
         lcs_pkg::HALT_ALL: halt = |st.alm;
         lcs_pkg::HALT_NOT_LEVEL: halt = |st.alm[3:1];
         default: halt = st.alm[lcs_pkg::AL_LOW];
      endcase
      stall = susp_act | halt;
      // Timer monitoring in cycle mode has no completion timeout
      tout_on = mode_pulse | mon_ps;
      if (!mode_pulse && !mon_ps) begin
         done = st.tm >= lim_run;
      end else if (!mode_pulse) begin
         done = st.ps_seen && st.ht >= lim_hold;
      end else begin
         done = st.pcnt >= 23'(st.pulses[lcs_pkg::F_RUNP +: 16]) &&
            (!mon_ps || (st.ps_seen && st.ht >= lim_hold));
      end
      cnt_ok = sby_eff != 23'd0 && st.pcnt >= sby_eff;
      tim_ok = st.tm >= lim_sby;
      if (mode_pulse) begin
         sby_end = cnt_ok;
      end else if (st.pulses[lcs_pkg::F_SBP +: 16] == 16'h0000) begin
         sby_end = tim_ok;
      end else begin
         case (src)
            lcs_pkg::SRC_TIMER: sby_end = tim_ok;
            lcs_pkg::SRC_FIRST: sby_end = tim_ok | cnt_ok;
            default: sby_end = cnt_ok;
         endcase
      end
      set_wdog = mode_pulse && lim_wd != 11'h000 && st.wd == lim_wd &&
         !pulse_rise;
      set_alm = '0;
      set_alm[lcs_pkg::AL_LOW] = low_lvl;
      set_alm[lcs_pkg::AL_WDOG] = set_wdog;
      set_alm[lcs_pkg::AL_TOUT] = st.ph == lcs_pkg::PH_LUBE && !stall &&
         tout_on && !done && st.tm >= lim_tout;
      set_alm[lcs_pkg::AL_SBY] = st.ph == lcs_pkg::PH_STANDBY && !stall &&
         !mode_pulse && src == lcs_pkg::SRC_TOUT_CNT && tim_ok;
      if (st.alm[lcs_pkg::AL_LOW]) begin
         code = lcs_pkg::CODE_LOW;
      end else if (st.alm[lcs_pkg::AL_WDOG]) begin
         code = lcs_pkg::CODE_WDOG;
      end else if (st.alm[lcs_pkg::AL_TOUT]) begin
         code = lcs_pkg::CODE_TOUT;
      end else begin
         code = lcs_pkg::CODE_SBY;
      end
      hit = 1'b1;
      case (paddr_in)
         lcs_pkg::A_CTRL: rd = st.ctrl;
         lcs_pkg::A_STANDBY: rd = st.sby;
         lcs_pkg::A_TIMES: rd = st.times;
         lcs_pkg::A_COUNTS: rd = st.counts;
         lcs_pkg::A_PULSES: rd = st.pulses;
         lcs_pkg::A_WDOG: rd = st.wdog;
         lcs_pkg::A_ALM_CLR: rd = '0;
         lcs_pkg::A_STATUS: begin
            rd = '0;
            rd[lcs_pkg::S_PH +: 3] = st.ph;
            rd[lcs_pkg::S_PUMP] = st.pump;
            rd[lcs_pkg::S_ALM +: 4] = st.alm;
            rd[lcs_pkg::S_CYC +: 9] = st.cyc;
            rd[lcs_pkg::S_SUSP] = susp_act;
            rd[lcs_pkg::S_HALT] = halt;
         end
         default: begin
            rd = '0;
            hit = 1'b0;
         end
      endcase
      wr = psel_in & penable_in & st.ack & pwrite_in;
   end

   always_comb begin
      n = st;
      // One wait state so that read data leaves a flip-flop
      n.ack = psel_in & penable_in & ~st.ack;
      if (psel_in && penable_in && !st.ack) begin
         n.rdata = rd;
         n.err = ~hit;
      end
      if (wr && hit) begin
         case (paddr_in)
            lcs_pkg::A_CTRL: n.ctrl = pwdata_in & lcs_pkg::CTRL_MASK;
            lcs_pkg::A_STANDBY: n.sby = pwdata_in & lcs_pkg::STANDBY_MASK;
            lcs_pkg::A_TIMES: n.times = pwdata_in;
            lcs_pkg::A_COUNTS: n.counts = pwdata_in & lcs_pkg::COUNTS_MASK;
            lcs_pkg::A_PULSES: n.pulses = pwdata_in;
            lcs_pkg::A_WDOG: n.wdog = pwdata_in & lcs_pkg::WDOG_MASK;
            default: n.ctrl = st.ctrl;
         endcase
         if (paddr_in == lcs_pkg::A_CTRL && pwdata_in[lcs_pkg::B_RESTORE])
         begin
            n.ctrl = lcs_pkg::CTRL_RST;
            n.sby = lcs_pkg::STANDBY_RST;
            n.times = lcs_pkg::TIMES_RST;
            n.counts = lcs_pkg::COUNTS_RST;
            n.pulses = lcs_pkg::PULSES_RST;
            n.wdog = lcs_pkg::WDOG_RST;
         end
      end
      // A new alarm beats a clear written in the same cycle
      n.alm = st.alm | set_alm;
      if (wr && paddr_in == lcs_pkg::A_ALM_CLR) begin
         n.alm = (st.alm & ~pwdata_in[3:0]) | set_alm;
      end
      n.pre = tick ? '0 : st.pre + 23'd1;
      if (!mode_pulse || pulse_rise) begin
         n.wd = '0;
      end else if (tick && !susp_act && st.wd != lim_wd) begin
         n.wd = st.wd + 11'd1;
      end
      if (!stall && tick && st.tm != '1) begin
         n.tm = st.tm + 22'd1;
      end
      if (!stall && pulse_rise) begin
         n.pcnt = st.pcnt + 23'd1;
      end
      case (st.ph)
         lcs_pkg::PH_BOOT: begin
            n.boot = st.boot + 2'd1;
            n.tm = '0;
            n.pcnt = '0;
            if (st.boot == lcs_pkg::BOOT_WAIT) begin
               case (st.ctrl[lcs_pkg::B_POS +: 2])
                  lcs_pkg::POS_STANDBY: n.ph = lcs_pkg::PH_STANDBY;
                  lcs_pkg::POS_LUBE: n.ph = lcs_pkg::PH_LUBE;
                  default: n.ph = resume_lvl ? lcs_pkg::PH_LUBE :
                     lcs_pkg::PH_STANDBY;
               endcase
               if (n.ph == lcs_pkg::PH_LUBE) begin
                  n.target = 9'(st.counts[lcs_pkg::F_CYC +: 8]) +
                     9'(st.counts[lcs_pkg::F_INIT +: 8]);
                  n.first = 1'b0;
               end
            end
         end
         lcs_pkg::PH_STANDBY: begin
            if (!stall && sby_end) begin
               n.ph = lcs_pkg::PH_LUBE;
               n.tm = '0;
               n.pcnt = '0;
               n.ps_seen = 1'b0;
               n.ht = '0;
               n.cyc = '0;
               n.target = 9'(st.counts[lcs_pkg::F_CYC +: 8]) +
                  (st.first ? 9'(st.counts[lcs_pkg::F_INIT +: 8]) : 9'h000);
               n.first = 1'b0;
            end
         end
         lcs_pkg::PH_LUBE: begin
            if (!stall) begin
               if (mon_ps && ps_lvl) begin
                  n.ps_seen = 1'b1;
               end
               if (st.ps_seen && tick && st.ht != '1) begin
                  n.ht = st.ht + 12'd1;
               end
               if (done || set_alm[lcs_pkg::AL_TOUT]) begin
                  n.cyc = st.cyc + 9'd1;
                  n.tm = '0;
                  n.pcnt = '0;
                  n.ps_seen = 1'b0;
                  n.ht = '0;
                  if (st.cyc + 9'd1 >= st.target) begin
                     n.ph = lcs_pkg::PH_STANDBY;
                  end else if (lim_gap != '0) begin
                     n.ph = lcs_pkg::PH_GAP;
                  end
               end
            end
         end
         lcs_pkg::PH_GAP: begin
            if (!stall && st.tm >= lim_gap) begin
               n.ph = lcs_pkg::PH_LUBE;
               n.tm = '0;
               n.pcnt = '0;
            end
         end
         default: n.ph = lcs_pkg::PH_STANDBY;
      endcase
      n.pump = st.ph == lcs_pkg::PH_LUBE && !stall;
      if (st.alm == '0) begin
         n.ry = lcs_pkg::RY_GAP;
         n.rcnt = '0;
         n.rn = '0;
      end else if (tick) begin
         n.rcnt = st.rcnt + 5'd1;
         case (st.ry)
            lcs_pkg::RY_GAP: begin
               if (st.rcnt == 5'(lcs_pkg::BURST_GAP_TICKS - 1)) begin
                  n.ry = lcs_pkg::RY_ON;
                  n.rcnt = '0;
               end
            end
            lcs_pkg::RY_ON: begin
               if (st.rcnt == 5'(lcs_pkg::BURST_TICKS - 1)) begin
                  n.ry = lcs_pkg::RY_OFF;
                  n.rcnt = '0;
               end
            end
            default: begin
               if (st.rcnt == 5'(lcs_pkg::BURST_TICKS - 1)) begin
                  n.rcnt = '0;
                  n.rn = st.rn + 4'd1;
                  n.ry = lcs_pkg::RY_ON;
                  if (st.rn + 4'd1 >= code) begin
                     n.rn = '0;
                     n.ry = lcs_pkg::RY_GAP;
                  end
               end
            end
         endcase
      end
      // Relay is held energised while healthy so a broken wire reads as alarm
      n.relay = (st.alm == '0) || (st.ctrl[lcs_pkg::B_STYLE] &&
         n.ry == lcs_pkg::RY_ON);
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         st <= '0;
         st.ctrl <= lcs_pkg::CTRL_RST;
         st.sby <= lcs_pkg::STANDBY_RST;
         st.times <= lcs_pkg::TIMES_RST;
         st.counts <= lcs_pkg::COUNTS_RST;
         st.pulses <= lcs_pkg::PULSES_RST;
         st.wdog <= lcs_pkg::WDOG_RST;
         st.ph <= lcs_pkg::PH_BOOT;
         st.ry <= lcs_pkg::RY_GAP;
         st.first <= 1'b1;
         st.relay <= 1'b1;
      end else begin
         st <= n;
      end
   end

   assign prdata_out = st.rdata;
   assign pready_out = st.ack;
   assign pslverr_out = st.ack & st.err;
   assign pump_on_out = st.pump;
   assign alarm_relay_out = st.relay;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   property p_pump_cause;
      pump_on_out |-> $past(st.ph == lcs_pkg::PH_LUBE && !stall);
   endproperty
   a_pump_cause: assert property (p_pump_cause)
      else $error("pump on outside unstalled lube phase");
   property p_halt_all;
      st.ctrl[lcs_pkg::B_HALT +: 2] == lcs_pkg::HALT_ALL && st.alm != '0
         |=> !pump_on_out;
   endproperty
   a_halt_all: assert property (p_halt_all)
      else $error("pump runs during alarm with halt on all");
   property p_relay_std;
      !st.ctrl[lcs_pkg::B_STYLE] && st.alm != '0 |=> !alarm_relay_out;
   endproperty
   a_relay_std: assert property (p_relay_std)
      else $error("standard relay not dropped on alarm");
   property p_tout;
      st.ph == lcs_pkg::PH_LUBE && !stall && tout_on && !done &&
         st.tm >= lim_tout |=> st.alm[lcs_pkg::AL_TOUT];
   endproperty
   a_tout: assert property (p_tout)
      else $error("completion timeout alarm missing");
   property p_restore;
      wr && paddr_in == lcs_pkg::A_CTRL && pwdata_in[lcs_pkg::B_RESTORE]
         |=> st.times == lcs_pkg::TIMES_RST && st.ctrl == lcs_pkg::CTRL_RST;
   endproperty
   a_restore: assert property (p_restore)
      else $error("factory restore did not reload defaults");
   property p_gap_count;
      st.ph == lcs_pkg::PH_GAP |-> st.cyc < st.target;
   endproperty
   a_gap_count: assert property (p_gap_count)
      else $error("gap entered after last cycle of phase");
   property p_wdog;
      set_wdog |=> st.alm[lcs_pkg::AL_WDOG];
   endproperty
   a_wdog: assert property (p_wdog)
      else $error("pulse watchdog alarm missing");
   property p_pulse_once;
      pulse_rise |=> !pulse_rise;
   endproperty
   a_pulse_once: assert property (p_pulse_once)
      else $error("pulse counted on two cycles");
   property p_sby_timer;
      st.ph == lcs_pkg::PH_STANDBY && !stall && !mode_pulse &&
         src == lcs_pkg::SRC_TIMER && tim_ok |=> st.ph == lcs_pkg::PH_LUBE;
   endproperty
   a_sby_timer: assert property (p_sby_timer)
      else $error("standby timer expiry did not start lube");
   property p_run_end;
      st.ph == lcs_pkg::PH_LUBE && !stall && !mode_pulse && !mon_ps &&
         st.tm >= lim_run && st.cyc + 9'd1 >= st.target
         |=> st.ph == lcs_pkg::PH_STANDBY;
   endproperty
   a_run_end: assert property (p_run_end)
      else $error("timed lube cycle did not end the phase");
endmodule

//--- pkg/lcs_pkg.sv
// Constants, encodings and register map of the lubrication cycle sequencer
package lcs_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_S = 1000 / TICK_MS;
   localparam int BURST_MS = 500;
   localparam int BURST_GAP_MS = 2000;
   localparam int BURST_TICKS = BURST_MS / TICK_MS;
   localparam int BURST_GAP_TICKS = BURST_GAP_MS / TICK_MS;
   localparam logic [1:0] BOOT_WAIT = 2'h3;

   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STANDBY = 12'h004;
   localparam logic [11:0] A_TIMES = 12'h008;
   localparam logic [11:0] A_COUNTS = 12'h00C;
   localparam logic [11:0] A_PULSES = 12'h010;
   localparam logic [11:0] A_WDOG = 12'h014;
   localparam logic [11:0] A_STATUS = 12'h018;
   localparam logic [11:0] A_ALM_CLR = 12'h01C;

   localparam int B_MODE = 0;
   localparam int B_MON = 1;
   localparam int B_SRC = 2;
   localparam int B_POS = 4;
   localparam int B_STYLE = 6;
   localparam int B_HALT = 7;
   localparam int B_HOLD = 9;
   localparam int B_SCALE = 10;
   localparam int B_RESTORE = 31;
   localparam int F_TOUT = 0;
   localparam int F_RUN = 8;
   localparam int F_GAP = 16;
   localparam int F_PSH = 24;
   localparam int F_CYC = 0;
   localparam int F_INIT = 8;
   localparam int F_SBP = 0;
   localparam int F_RUNP = 16;
   localparam int S_PH = 0;
   localparam int S_PUMP = 3;
   localparam int S_ALM = 4;
   localparam int S_CYC = 8;
   localparam int S_SUSP = 17;
   localparam int S_HALT = 18;

   localparam logic [31:0] CTRL_RST = 32'h000000A0;
   localparam logic [31:0] STANDBY_RST = 32'h00000168;
   localparam logic [31:0] TIMES_RST = 32'h050A1E1E;
   localparam logic [31:0] COUNTS_RST = 32'h00000001;
   localparam logic [31:0] PULSES_RST = 32'h00010001;
   localparam logic [31:0] WDOG_RST = 32'h0000000F;
   localparam logic [31:0] CTRL_MASK = 32'h00000FFF;
   localparam logic [31:0] STANDBY_MASK = 32'h0007FFFF;
   localparam logic [31:0] COUNTS_MASK = 32'h0000FFFF;
   localparam logic [31:0] WDOG_MASK = 32'h000007FF;

   localparam logic [1:0] SRC_TIMER = 2'h0;
   localparam logic [1:0] SRC_FIRST = 2'h1;
   localparam logic [1:0] SRC_COUNT = 2'h2;
   localparam logic [1:0] SRC_TOUT_CNT = 2'h3;
   localparam logic [1:0] POS_STANDBY = 2'h0;
   localparam logic [1:0] POS_LUBE = 2'h1;
   localparam logic [1:0] HALT_NONE = 2'h0;
   localparam logic [1:0] HALT_ALL = 2'h1;
   localparam logic [1:0] HALT_NOT_LEVEL = 2'h2;
   localparam logic [1:0] SCALE_10 = 2'h1;
   localparam logic [1:0] SCALE_100 = 2'h2;

   localparam int AL_LOW = 0;
   localparam int AL_TOUT = 1;
   localparam int AL_SBY = 2;
   localparam int AL_WDOG = 3;
   localparam logic [3:0] CODE_LOW = 4'h1;
   localparam logic [3:0] CODE_WDOG = 4'h2;
   localparam logic [3:0] CODE_TOUT = 4'h5;
   localparam logic [3:0] CODE_SBY = 4'h8;

   typedef enum logic [2:0] {PH_BOOT, PH_STANDBY, PH_LUBE, PH_GAP}
      lcs_phase_e;
   typedef enum logic [1:0] {RY_GAP, RY_ON, RY_OFF} lcs_relay_e;
endpackage

//--- hdl/lcs_sync_edge.sv
// Two-stage synchroniser with rising edge detect for one field input
`timescale 1ns/1ps
module lcs_sync_edge (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic async_in,
   output logic level_out,
   output logic rise_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } lcs_sync_s;
   lcs_sync_s st;
   lcs_sync_s next_st;

   always_comb begin
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_out = st.s2;
   // Edge is taken from the second and third stage only
   assign rise_out = st.s2 & ~st.s3;
endmodule

//--- verif/lcs_field_model.sv
// Field-side model: pressure switch and pulse source facing the sequencer
`timescale 1ns/1ps
module lcs_field_model #(
   parameter int PS_DELAY = 40,
   parameter int PULSE_HALF = 30
) (
   input wire logic sys_clk_in,
   input wire logic pump_on_in,
   input wire logic pulse_en_in,
   output logic pressure_sw_out,
   output logic pulse_out
);
   int ps_cnt = 0;
   int pl_cnt = 0;
   initial pressure_sw_out = 1'b0;
   initial pulse_out = 1'b0;
   // Pressure builds only while the pump runs, drops as soon as it stops
   always @(posedge sys_clk_in) begin
      ps_cnt <= pump_on_in ? ps_cnt + 1 : 0;
      pressure_sw_out <= pump_on_in && ps_cnt >= PS_DELAY;
      pl_cnt <= (pl_cnt == PULSE_HALF - 1) ? 0 : pl_cnt + 1;
      // Pulses stop dead when disabled, so a missing pulse can be provoked
      if (pl_cnt == 0) begin
         pulse_out <= pulse_en_in ? ~pulse_out : 1'b0;
      end
   end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the lubrication cycle sequencer
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [11:0] a; logic [31:0] v;} lcs_row_s;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h00000000;
   logic low = 1'b0;
   logic susp = 1'b0;
   logic pe = 1'b0;
   logic [31:0] prd, q;
   logic rdy, serr, ps, pls, pump, rly, e;
   int err_count = 0;
   int n_checks = 0;
   int n;
   lcs_row_s rows [7];
   always #10 clk = ~clk;
   // Ten cycles per tick keeps one second at 100 cycles
   lcs_sequencer #(.TICK_CYC(10)) dut_u (.sys_clk_in(clk), .resetn_in(rstn),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
      .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
      .pslverr_out(serr), .pressure_sw_in(ps), .pulse_in(pls),
      .low_level_in(low), .suspend_in(susp), .resume_lube_in(1'b1),
      .pump_on_out(pump), .alarm_relay_out(rly));
   lcs_field_model fm_u (.sys_clk_in(clk), .pump_on_in(pump),
      .pulse_en_in(pe), .pressure_sw_out(ps), .pulse_out(pls));
   task automatic close_out;
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] x,
      input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         err_count++;
         $display("unexpected %s exp %h got %h", s, x, g);
      end
   endtask
   // Counts cycles until pump (r=0) or relay (r=1) shows v
   task automatic wt(input string s, input bit r, input logic v,
      input int lo, input int hi);
      n = 0;
      while ((r ? rly : pump) !== v) begin
         @(posedge clk);
         n++;
         if (n > hi) begin
            err_count++;
            $display("unexpected %s exp %0d got timeout", s, hi);
            close_out();
         end
      end
      n_checks++;
      if (n < lo) begin
         err_count++;
         $display("unexpected %s exp %0d..%0d got %0d", s, lo, hi, n);
      end
   endtask
   // One APB transfer; psel drops for a cycle so no signal is set twice
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (k > 20) begin
            err_count++;
            $display("unexpected pready exp 1 got timeout");
            close_out();
         end
      end while (rdy !== 1'b1);
      q = prd;
      e = serr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      rows = '{'{lcs_pkg::A_CTRL, lcs_pkg::CTRL_RST},
         '{lcs_pkg::A_STANDBY, lcs_pkg::STANDBY_RST},
         '{lcs_pkg::A_TIMES, lcs_pkg::TIMES_RST},
         '{lcs_pkg::A_COUNTS, lcs_pkg::COUNTS_RST},
         '{lcs_pkg::A_PULSES, lcs_pkg::PULSES_RST},
         '{lcs_pkg::A_WDOG, lcs_pkg::WDOG_RST},
         '{lcs_pkg::A_ALM_CLR, 32'h00000000}};
      repeat (3) @(posedge clk);
      chk("pump in reset", 32'h0, {31'h0, pump});
      chk("relay in reset", 32'h1, {31'h0, rly});
      rstn <= 1'b1;
      wt("boot lube", 1'b0, 1'b1, 3, 8);
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         chk("reset value", rows[i].v, q);
      end
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      apb(1'b1, lcs_pkg::A_STANDBY, 32'h00000001);
      wt("lube run", 1'b0, 1'b0, 2900, 3010);
      wt("standby", 1'b0, 1'b1, 90, 112);
      low <= 1'b1;
      wt("relay drop", 1'b1, 1'b0, 3, 8);
      wt("halt pump", 1'b0, 1'b0, 0, 8);
      apb(1'b0, lcs_pkg::A_STATUS, 32'h0);
      chk("low alarm", 32'h1, 32'(q[lcs_pkg::S_ALM + lcs_pkg::AL_LOW]));
      low <= 1'b0;
      repeat (5) @(posedge clk);
      apb(1'b1, lcs_pkg::A_ALM_CLR, 32'h0000000F);
      wt("relay back", 1'b1, 1'b1, 0, 4);
      apb(1'b1, lcs_pkg::A_CTRL, lcs_pkg::CTRL_RST | 32'h00000040);
      low <= 1'b1;
      wt("coded start", 1'b1, 1'b0, 3, 8);
      wt("coded gap", 1'b1, 1'b1, 185, 212);
      wt("coded burst", 1'b1, 1'b0, 49, 51);
      low <= 1'b0;
      repeat (5) @(posedge clk);
      apb(1'b1, lcs_pkg::A_ALM_CLR, 32'h0000000F);
      apb(1'b1, lcs_pkg::A_CTRL, lcs_pkg::CTRL_RST | 32'h00000200);
      wt("pump resumes", 1'b0, 1'b1, 0, 3300);
      susp <= 1'b1;
      wt("suspend", 1'b0, 1'b0, 3, 8);
      susp <= 1'b0;
      wt("unsuspend", 1'b0, 1'b1, 3, 8);
      apb(1'b1, lcs_pkg::A_CTRL, 32'h80000000);
      apb(1'b0, lcs_pkg::A_CTRL, 32'h0);
      chk("restore ctrl", lcs_pkg::CTRL_RST, q);
      apb(1'b0, lcs_pkg::A_STANDBY, 32'h0);
      chk("restore standby", lcs_pkg::STANDBY_RST, q);
      // Pulse mode, no halt: one pulse ends each phase, period 60 cycles
      pe <= 1'b1;
      apb(1'b1, lcs_pkg::A_CTRL, 32'h00000001);
      wt("pulse lube end", 1'b0, 1'b0, 0, 80);
      wt("pulse standby", 1'b0, 1'b1, 55, 65);
      pe <= 1'b0;
      wt("pulse watchdog", 1'b1, 1'b0, 120, 170);
      close_out();
   end
endmodule
